// ===== hdl/dcff_regs.svh
// offsets, field positions and reset values of the dual clock fifo
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH

// register byte offsets on the bus
`define DCFF_OFS_FLAGS     8'h00
`define DCFF_OFS_IRQ_STAT  8'h04
`define DCFF_OFS_IRQ_MASK  8'h08
`define DCFF_OFS_COUNTS    8'h0c

// flag register bit positions
`define DCFF_FLG_EMPTY     0
`define DCFF_FLG_ALMOST_EMPTY_FLAG    1
`define DCFF_FLG_FULL      2
`define DCFF_FLG_ALMOST_FULL_FLAG     3
`define DCFF_FLG_READ_ERROR_FLAG     4
`define DCFF_FLG_WRITE_ERROR_FLAG     5

// event bit positions in status and mask
`define DCFF_EV_WRITE_ERROR_FLAG      0
`define DCFF_EV_READ_ERROR_FLAG      1
`define DCFF_EV_FULL       2
`define DCFF_EV_EMPTY      3
`define DCFF_EV_W          4

// count register field position
`define DCFF_CNT_WR_LSB    16

// reset values
`define DCFF_RST_EMPTY     1'b1
`define DCFF_RST_ALMOST_EMPTY_FLAG    1'b1
`define DCFF_RST_FULL      1'b0
`define DCFF_RST_ALMOST_FULL_FLAG     1'b0
`define DCFF_RST_ERR       1'b0
`define DCFF_RST_MASK      4'h0
`define DCFF_RST_STAT      4'h0

`endif

// ===== hdl/dcff_pkg.sv
// types shared by the dual clock fifo modules
package dcff_pkg;

  // one-hot state of the fall-through output stage
  typedef enum logic [1:0] {
    DCFF_OUT_IDLE  = 2'b01,
    DCFF_OUT_VALID = 2'b10
  } dcff_out_state_t;

endpackage : dcff_pkg

// ===== hdl/dcff_sync.sv
// two-stage synchroniser for a gray-coded pointer
`timescale 1ns/1ps
module dcff_sync
  import dcff_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;

endmodule : dcff_sync

// ===== hdl/dcff_wb_regs.sv
// wishbone slave with flag view, sticky events, mask and interrupt
`timescale 1ns/1ps
`include "dcff_regs.svh"
module dcff_wb_regs
  import dcff_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [`DCFF_EV_W-1:0] ev_i,
  input  wire logic [31:0]          flags_i,
  input  wire logic [31:0]          counts_i,
  output logic                      irq_o
);

  logic                  ack_q;
  logic [31:0]           dat_q;
  logic [`DCFF_EV_W-1:0] stat_q;
  logic [`DCFF_EV_W-1:0] mask_q;
  logic [`DCFF_EV_W-1:0] stat_d;
  logic [31:0]           rd_mux;
  logic                  req;
  logic                  wr_go;
  logic                  clr_hit;
  logic                  mask_hit;

  // decode; a write lands on the edge where ack is seen
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_go    = req & wb_we_i & ack_q & wb_sel_i[0];
  assign clr_hit  = wr_go & (wb_adr_i == `DCFF_OFS_IRQ_STAT);
  assign mask_hit = wr_go & (wb_adr_i == `DCFF_OFS_IRQ_MASK);

  // read selection, unmapped reads give zero
  assign rd_mux =
    (wb_adr_i == `DCFF_OFS_FLAGS)    ? flags_i :
    (wb_adr_i == `DCFF_OFS_IRQ_STAT) ? {28'h0000000, stat_q} :
    (wb_adr_i == `DCFF_OFS_IRQ_MASK) ? {28'h0000000, mask_q} :
    (wb_adr_i == `DCFF_OFS_COUNTS)   ? counts_i : 32'h00000000;

  // new events win over a write-one clear
  assign stat_d = (stat_q & ~(clr_hit ? wb_dat_i[`DCFF_EV_W-1:0]
                                      : `DCFF_RST_STAT)) | ev_i;

  // single-wait answer, ack lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q) ? rd_mux : dat_q;
    end
  end

  // sticky status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `DCFF_RST_STAT;
      mask_q <= `DCFF_RST_MASK;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_hit ? wb_dat_i[`DCFF_EV_W-1:0] : mask_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o    = |(stat_q & mask_q); // level while unmasked bit set

endmodule : dcff_wb_regs

// ===== hdl/dcff_fifo.sv
// dual-domain fifo core with flags, pointer counts and register port
//
// Notes on behaviour
// [RULE1] Empty, almost-empty and read-error flags change only on read-side edges.
// [RULE2] Full, almost-full and write-error flags change only on write-side edges.
// [RULE3] Each pointer count output changes only on its own side's edge.
// [RULE4] Reset returns every flag and both pointer counts to their reset state.
// [RULE5] A write into an empty fifo lands at the location to be read next.
// [RULE6] Empty falls three read cycles after the first write, four in fall-through.
// [RULE7] Fall-through mode preloads the first word and bumps the read count by one.
// [RULE8] In fall-through the first word shows without a read; otherwise only on read. The unregistered single-clock path shows it without a read too.
// [RULE9] Near-coincident edges may delay empty by one more read cycle.
// [RULE10] Single-clock mode skips the crossing, so it is shorter than dual mode with or without output register.
// [RULE11] Pointers cross sides gray coded through two-stage synchronisers.
// [RULE12] Write error follows write request while full, and that write is dropped.
// [RULE13] Read error marks a read with no data, and data out then holds. In fall-through a read error in the preload cycle still moves data out.
// [RULE14] Full falls three write cycles after the first read from a full fifo.
`timescale 1ns/1ps
`include "dcff_regs.svh"
module dcff_fifo
  import dcff_pkg::*;
#(
  parameter int DW        = 32,
  parameter int AW        = 9,
  parameter int AE_OFFSET = 5,
  parameter int AF_OFFSET = 4,
  parameter bit FIRST_WORD_FALL_THROUGH_MODE      = 1'b0,
  parameter bit SYNC_MODE = 1'b0,
  parameter bit OUT_REG   = 1'b1
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [DW-1:0] write_data_in_i,
  input  wire logic          write_request_i,
  input  wire logic          read_request_i,
  output logic      [DW-1:0] read_data_o,
  output logic               empty_o,
  output logic               almost_empty_flag_o,
  output logic               full_o,
  output logic               almost_full_flag_o,
  output logic               read_error_flag_o,
  output logic               write_error_flag_o,
  output logic      [AW:0]   read_pointer_count_o,
  output logic      [AW:0]   write_pointer_count_o,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  output logic               irq_o
);

  localparam int PW    = AW + 1;
  localparam int DEPTH = 1 << AW;
  localparam logic [PW-1:0] AF_LVL = PW'(DEPTH - AF_OFFSET);
  localparam logic [PW-1:0] AE_LVL = PW'(AE_OFFSET);

  // storage
  logic [DW-1:0] mem [DEPTH];

  // write side state
  logic [PW-1:0] wbin_q;
  logic [PW-1:0] wgray_q;
  logic          full_q;
  logic          almost_full_flag_q;
  logic          werr_q;
  // read side state
  logic [PW-1:0] rbin_q;
  logic [PW-1:0] rgray_q;
  logic          sempty_q;
  logic          empty_q;
  logic          almost_empty_flag_q;
  logic          rerr_q;
  logic [DW-1:0] dout_q;
  dcff_out_state_t st_q;
  dcff_out_state_t st_d;

  // crossed pointers
  logic [PW-1:0] rgray_s;
  logic [PW-1:0] wgray_s;
  logic [PW-1:0] rgray_w;
  logic [PW-1:0] wgray_r;
  logic [PW-1:0] rbin_w;
  logic [PW-1:0] wbin_r;

  // next values
  logic          wr_ok;
  logic [PW-1:0] wbin_d;
  logic [PW-1:0] wgray_d;
  logic [PW-1:0] wfill_d;
  logic          full_d;
  logic          almost_full_flag_d;
  logic          werr_d;
  logic          rd_fetch;
  logic [PW-1:0] rbin_d;
  logic [PW-1:0] rgray_d;
  logic [PW-1:0] rfill_d;
  logic          sempty_d;
  logic          empty_d;
  logic          almost_empty_flag_d;
  logic          rerr_d;
  logic          out_idle;
  logic [`DCFF_EV_W-1:0] ev;
  logic [31:0]   flags_w;
  logic [31:0]   counts_w;

  // gray pointers through two-stage synchronisers
  dcff_sync #(.W(PW)) u_r2w (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rgray_q),
    .q_o   (rgray_s)
  ); // [RULE11]

  dcff_sync #(.W(PW)) u_w2r (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (wgray_q),
    .q_o   (wgray_s)
  ); // [RULE11]

  // single-clock mode skips the crossing for a shorter path
  assign rgray_w = SYNC_MODE ? rgray_q : rgray_s; // [RULE10]
  assign wgray_r = SYNC_MODE ? wgray_q : wgray_s; // [RULE10]

  // gray to binary, one xor reduction per bit
  for (genvar i = 0; i < PW; i++) begin : g_g2b
    assign rbin_w[i] = ^rgray_w[PW-1:i];
    assign wbin_r[i] = ^wgray_r[PW-1:i];
  end

  // write side next state, a write while full is dropped
  assign wr_ok   = write_request_i & ~full_q; // [RULE12]
  assign wbin_d  = wbin_q + PW'(wr_ok);
  assign wgray_d = wbin_d ^ (wbin_d >> 1);
  assign wfill_d = wbin_d - rbin_w;
  assign full_d  = wgray_d == {~rgray_w[PW-1:PW-2], rgray_w[PW-3:0]}; // [RULE14]
  assign almost_full_flag_d = wfill_d >= AF_LVL;
  assign werr_d  = write_request_i & full_q; // [RULE12]

  // write side registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wbin_q  <= '0; // [RULE4]
      wgray_q <= '0;
      full_q  <= `DCFF_RST_FULL;
      almost_full_flag_q <= `DCFF_RST_ALMOST_FULL_FLAG;
      werr_q  <= `DCFF_RST_ERR;
    end else begin
      wbin_q  <= wbin_d; // [RULE3]
      wgray_q <= wgray_d;
      full_q  <= full_d; // [RULE2]
      almost_full_flag_q <= almost_full_flag_d;
      werr_q  <= werr_d;
    end
  end

  // storage write at the current write address
  always_ff @(posedge clk_i) begin
    if (wr_ok) begin
      mem[wbin_q[AW-1:0]] <= write_data_in_i; // [RULE5]
    end
  end

  // read fetch: on request, or a preload while fall-through stage is idle
  assign out_idle = st_q == DCFF_OUT_IDLE;
  assign rd_fetch = ~sempty_q &
                    (FIRST_WORD_FALL_THROUGH_MODE ? (out_idle | read_request_i) : read_request_i); // [RULE7]
  assign rbin_d   = rbin_q + PW'(rd_fetch);
  assign rgray_d  = rbin_d ^ (rbin_d >> 1);
  // empty from the pointer after this edge; crossing adds two cycles
  assign sempty_d = rgray_d == wgray_r; // [RULE6]
  assign rfill_d  = wbin_r - rbin_d;
  assign almost_empty_flag_d = rfill_d <= AE_LVL;

  // fall-through output stage
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DCFF_OUT_IDLE: begin
        if (rd_fetch) begin
          st_d = DCFF_OUT_VALID; // [RULE8]
        end
      end
      DCFF_OUT_VALID: begin
        if (read_request_i & ~rd_fetch) begin
          st_d = DCFF_OUT_IDLE;
        end
      end
    endcase
  end

  // visible empty: stage state in fall-through, else storage empty
  assign empty_d = FIRST_WORD_FALL_THROUGH_MODE ? (st_d == DCFF_OUT_IDLE) : sempty_d; // [RULE6]
  assign rerr_d  = read_request_i & (FIRST_WORD_FALL_THROUGH_MODE ? out_idle : sempty_q); // [RULE13]

  // read side registers; late sync edge only adds a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rbin_q   <= '0; // [RULE4]
      rgray_q  <= '0;
      sempty_q <= `DCFF_RST_EMPTY;
      empty_q  <= `DCFF_RST_EMPTY;
      almost_empty_flag_q <= `DCFF_RST_ALMOST_EMPTY_FLAG;
      rerr_q   <= `DCFF_RST_ERR;
      st_q     <= DCFF_OUT_IDLE;
    end else begin
      rbin_q   <= rbin_d; // [RULE3]
      rgray_q  <= rgray_d;
      sempty_q <= sempty_d; // [RULE9]
      empty_q  <= empty_d; // [RULE1]
      almost_empty_flag_q <= almost_empty_flag_d & (FIRST_WORD_FALL_THROUGH_MODE ? st_d == DCFF_OUT_IDLE : 1'b1);
      rerr_q   <= rerr_d;
      st_q     <= FIRST_WORD_FALL_THROUGH_MODE ? st_d : DCFF_OUT_IDLE;
    end
  end

  // output data only moves on a real fetch, held on failed read unless a fall-through preload fetch lands in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_q <= '0;
    end else if (rd_fetch) begin
      dout_q <= mem[rbin_q[AW-1:0]]; // [RULE13]
    end
  end

  // unregistered single-clock path shows the head word directly
  assign read_data_o = (SYNC_MODE & ~OUT_REG) ? mem[rbin_q[AW-1:0]]
                                              : dout_q; // [RULE10]

  // flag and count outputs
  assign empty_o               = empty_q;
  assign almost_empty_flag_o   = almost_empty_flag_q;
  assign full_o                = full_q;
  assign almost_full_flag_o    = almost_full_flag_q;
  assign read_error_flag_o     = rerr_q;
  assign write_error_flag_o    = werr_q;
  assign read_pointer_count_o  = rbin_q;
  assign write_pointer_count_o = wbin_q;

  // interrupt events and register views
  assign ev[`DCFF_EV_WRITE_ERROR_FLAG] = werr_d;
  assign ev[`DCFF_EV_READ_ERROR_FLAG] = rerr_d;
  assign ev[`DCFF_EV_FULL]  = full_d & ~full_q;
  assign ev[`DCFF_EV_EMPTY] = empty_d & ~empty_q;

  assign flags_w = {26'h0000000, werr_q, rerr_q, almost_full_flag_q, full_q,
                    almost_empty_flag_q, empty_q};
  assign counts_w = {16'(wbin_q), 16'(rbin_q)};

  dcff_wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_we_i  (wb_we_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .ev_i     (ev),
    .flags_i  (flags_w),
    .counts_i (counts_w),
    .irq_o    (irq_o)
  );

endmodule : dcff_fifo

// ===== tb/dcff_chk.sv
// concurrent checks on the dual clock fifo ports
`timescale 1ns/1ps
module dcff_chk #(
  parameter int DW        = 32,
  parameter int AW        = 9,
  parameter bit FALL_THRU = 1'b0
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          write_request_i,
  input wire logic          read_request_i,
  input wire logic [DW-1:0] read_data_o,
  input wire logic          empty_o,
  input wire logic          almost_empty_flag_o,
  input wire logic          full_o,
  input wire logic          almost_full_flag_o,
  input wire logic          read_error_flag_o,
  input wire logic          write_error_flag_o,
  input wire logic [AW:0]   read_pointer_count_o,
  input wire logic [AW:0]   write_pointer_count_o
);
  localparam int CW = AW + 1;
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  // words held, from the two pointer counts
  wire logic [AW:0] fill_w = write_pointer_count_o - read_pointer_count_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rst_flags_a: assert property (disable iff (1'b0) rst_i |=>
    empty_o && almost_empty_flag_o && !full_o && !almost_full_flag_o
    && !read_error_flag_o && !write_error_flag_o
    && read_pointer_count_o == '0 && write_pointer_count_o == '0)
    else $error("flags not at reset state");
  wr_err_set_a: assert property (write_request_i && full_o
    |=> write_error_flag_o) else $error("write error missing");
  wr_err_clr_a: assert property (!write_request_i
    |=> !write_error_flag_o) else $error("write error stuck");
  rd_err_set_a: assert property (read_request_i && empty_o
    |=> read_error_flag_o) else $error("read error missing");
  rd_hold_a: assert property (!FALL_THRU && read_request_i &&
    empty_o |=> $stable(read_data_o)) else $error("data moved on bad read");
  wr_cnt_a: assert property (write_request_i && !full_o |=>
    write_pointer_count_o == CW'($past(write_pointer_count_o) + 1'b1))
    else $error("write count not advanced");
  wr_cnt_hold_a: assert property (!write_request_i
    |=> $stable(write_pointer_count_o)) else $error("write count moved");
  empty_lat_a: assert property (!FALL_THRU && empty_o &&
    write_request_i && fill_w == '0 |=> empty_o [*3] ##1 !empty_o)
    else $error("empty latency wrong");
  full_lat_a: assert property (!FALL_THRU && read_request_i &&
    !empty_o && fill_w == DEPTH |=> full_o [*3] ##1 !full_o)
    else $error("full latency wrong");
  ae_when_empty_a: assert property (empty_o |-> almost_empty_flag_o)
    else $error("almost empty low while empty");
  af_when_full_a: assert property (full_o |-> almost_full_flag_o)
    else $error("almost full low while full");

  // main scenarios reached
  cover property (write_error_flag_o);
  cover property (read_error_flag_o);
  cover property (full_o && read_request_i);
endmodule : dcff_chk

bind dcff_fifo dcff_chk #(.DW(DW), .AW(AW), .FALL_THRU(FIRST_WORD_FALL_THROUGH_MODE)) dcff_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .write_request_i(write_request_i),
  .read_request_i(read_request_i), .read_data_o(read_data_o),
  .empty_o(empty_o), .almost_empty_flag_o(almost_empty_flag_o),
  .full_o(full_o), .almost_full_flag_o(almost_full_flag_o),
  .read_error_flag_o(read_error_flag_o),
  .write_error_flag_o(write_error_flag_o),
  .read_pointer_count_o(read_pointer_count_o),
  .write_pointer_count_o(write_pointer_count_o));

// ===== tb/dcff_user.sv
// writer and reader user logic facing the fifo
`timescale 1ns/1ps
module dcff_user (
  input  wire logic        wr_go_i,
  input  wire logic        rd_go_i,
  input  wire logic        rude_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        full_i,
  input  wire logic        empty_i,
  output logic             write_request_o,
  output logic      [31:0] write_data_o,
  output logic             read_request_o
);
  // requests held back by the flags unless told to misbehave
  assign write_request_o = wr_go_i & (rude_i | ~full_i);
  assign read_request_o  = rd_go_i & (rude_i | ~empty_i);
  // data outside a write is inverted to expose late sampling
  assign write_data_o = write_request_o ? wdata_i : ~wdata_i;
endmodule : dcff_user

// ===== tb/dcff_fifo_tb.sv
// self-checking bench for the dual clock fifo
`timescale 1ns/1ps
module dcff_fifo_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_go = 1'b0, rd_go = 1'b0;
  logic        rude = 1'b0, cyc = 1'b0, stb = 1'b0, wbwe = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdata = 32'h0, wdat = 32'h0, wd, rdata, rdata_f, d_o, d;
  logic [31:0] q[$], lastw, w0;
  logic        wreq, rreq, empty, ae, full, af, rerr, werr, ack, irq;
  logic        empty_f, taken = 1'b0;
  logic [9:0]  rcnt, wcnt, rcnt_f;
  int          n_fail = 0, num_checks = 0, n_wr = 0, n_rd = 0, cyc_n = 0;
  int          seed, k, le, lf, i;

  // bench clock, 50 ns period
  always #25 clk_i = ~clk_i;

  dcff_user dcff_user_i (.wr_go_i(wr_go), .rd_go_i(rd_go), .rude_i(rude),
    .wdata_i(wdata), .full_i(full), .empty_i(empty),
    .write_request_o(wreq), .write_data_o(wd), .read_request_o(rreq));
  dcff_fifo dcff_fifo_i (.clk_i(clk_i), .rst_i(rst_i), .write_data_in_i(wd),
    .write_request_i(wreq), .read_request_i(rreq), .read_data_o(rdata),
    .empty_o(empty), .almost_empty_flag_o(ae), .full_o(full),
    .almost_full_flag_o(af), .read_error_flag_o(rerr),
    .write_error_flag_o(werr), .read_pointer_count_o(rcnt),
    .write_pointer_count_o(wcnt), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(wbwe), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(d_o), .wb_ack_o(ack), .irq_o(irq));
  // fall-through twin on the same requests
  dcff_fifo #(.FIRST_WORD_FALL_THROUGH_MODE(1'b1), .AE_OFFSET(6)) dcff_fifo_fw_i (.clk_i(clk_i),
    .rst_i(rst_i), .write_data_in_i(wd), .write_request_i(wreq),
    .read_request_i(rreq), .read_data_o(rdata_f), .empty_o(empty_f),
    .almost_empty_flag_o(), .full_o(), .almost_full_flag_o(),
    .read_error_flag_o(), .write_error_flag_o(),
    .read_pointer_count_o(rcnt_f), .write_pointer_count_o(),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(wbwe),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(), .wb_ack_o(), .irq_o());

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // count register image from the bench's own tallies
  function automatic logic [31:0] cnt_reg(input int w, input int r);
    return {6'h0, w[9:0], 6'h0, r[9:0]};
  endfunction : cnt_reg

  // classic single wishbone cycle, data lands in d
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] v);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= we;
    adr <= a;
    wdat <= v;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = d_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // scoreboard of accepted words, compared when read
  always @(posedge clk_i) begin
    if (!rst_i && wreq && full === 1'b0) begin
      q.push_back(wd);
      lastw = wd;
      n_wr++;
    end
    taken <= !rst_i && rreq && empty === 1'b0;
  end
  always @(negedge clk_i) begin
    if (taken) begin
      n_rd++;
      check(rdata, q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    seed = 37;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    check(32'({empty, ae, full, af, rerr, werr}), 32'h30);
    check(32'({rcnt, wcnt}), 32'h0);
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    check(d, 32'h3);
    $display("reset test done");
    wdata <= $random(seed);
    wr_go <= 1'b1;
    @(posedge clk_i);
    wr_go <= 1'b0;
    w0 = wdata;
    le = 0;
    lf = 0;
    for (k = 1; k < 9; k++) begin
      @(posedge clk_i);
      @(negedge clk_i);
      if (empty === 1'b0 && le == 0) le = k;
      if (empty_f === 1'b0 && lf == 0) lf = k;
    end
    check(le, 3);
    check(lf, 4);
    check(rdata, 32'h0);
    check(rdata_f, w0);
    check(32'(rcnt_f), 32'h1);
    @(posedge clk_i);
    rd_go <= 1'b1;
    @(posedge clk_i);
    rd_go <= 1'b0;
    $display("first word test done");
    // random streaming traffic
    repeat (300) begin
      @(posedge clk_i);
      wr_go <= 1'($random(seed));
      rd_go <= 1'($random(seed));
      wdata <= $random(seed);
    end
    wr_go <= 1'b1;
    rd_go <= 1'b0;
    for (i = 0; i < 700 && full !== 1'b1; i++) begin
      @(posedge clk_i);
      wdata <= $random(seed);
    end
    rude <= 1'b1;
    @(posedge clk_i);
    wr_go <= 1'b0;
    rude <= 1'b0;
    @(negedge clk_i);
    check(32'(werr), 32'h1);
    check(32'(wcnt), 32'(n_wr[9:0]));
    @(negedge clk_i);
    check(32'(werr), 32'h0);
    @(posedge clk_i);
    rd_go <= 1'b1;
    @(posedge clk_i);
    rd_go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      @(negedge clk_i);
      k++;
    end while (full === 1'b1 && k < 9);
    check(k, 3);
    @(posedge clk_i);
    rd_go <= 1'b1;
    for (i = 0; i < 700 && empty !== 1'b1; i++) @(posedge clk_i);
    rude <= 1'b1;
    @(posedge clk_i);
    rd_go <= 1'b0;
    rude <= 1'b0;
    @(negedge clk_i);
    check(32'(rerr), 32'h1);
    check(rdata, lastw);
    $display("full and empty test done");
    @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    check(d, 32'hf);
    check(32'(irq), 32'h0);
    wb(1'b1, 8'h08, 32'h2);
    check(32'(irq), 32'h1);
    wb(1'b1, 8'h04, 32'h2);
    check(32'(irq), 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    check(d, 32'hd);
    wb(1'b0, 8'h0c, 32'h0);
    check(d, cnt_reg(n_wr, n_rd));
    wb(1'b1, 8'h10, 32'hffff);
    wb(1'b0, 8'h10, 32'h0);
    check(d, 32'h0);
    $display("register test done");
    results();
  end
endmodule : dcff_fifo_tb
